// ---- logic/fcae_engine.sv ----
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
// Functional notes
// - fuse commands are taken only while the command enable bit is one.
// - 8-bit address holder, reset zero, selects fuse location for read/write.
// - 8-bit data holder, supplies write byte and receives fetched byte.
// - writing control bit 0 starts programming; cleared when write completes.
// - writing control bit 1 starts a fetch; cleared once data is held.
// - writing control bit 3 seals the fuse space; cleared when done.
// - run status bit 0 shows fuse space used.
// - run status bit 1 shows fuse space sealed.
// - run status bit 2 shows the status check has been performed.
// - result bit 0 shows last programming succeeded.
// - result bit 1 set when a programming request was refused.
// - result bit 4 shows seal operation succeeded.
// - result bit 5 shows checksum test of fuse contents passed.
// - an all-zero use-select register bypasses stored configuration.
module fcae_engine
	import fcae_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rstn,
	// avalon-mm slave
	input  wire logic [BUS_AW-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [BUS_DW-1:0] avs_writedata,
	output logic      [BUS_DW-1:0] avs_readdata,
	output logic                   avs_waitrequest,
	// interrupt
	output logic                   irq,
	// configuration select
	output logic                   cfg_use_store
);

	function automatic logic hit(input logic [BUS_AW-1:0] a,
		input logic [7:0] idx);
		hit = (a[BUS_AW-1:2] == idx) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic [7:0] crc8(input logic [7:0] c,
		input logic [7:0] d);
		logic [7:0] v;
		v = c ^ d;
		for (int i = 0; i < 8; i++)
			v = v[7] ? ((v << 1) ^ CRC_POLY) : (v << 1);
		crc8 = v;
	endfunction

	fcae_state_e       state_r;
	fcae_state_e       state_nxt;
	logic        [7:0] cmd_en_r;
	logic        [7:0] addr_r;
	logic        [7:0] data_r;
	logic        [7:0] ctrl_r;
	logic        [7:0] use_r;
	logic        [7:0] merge_r;
	logic        [7:0] cnt_r;
	logic        [8:0] chk_cnt_r;
	logic        [7:0] crc_r;
	logic              used_r;
	logic              sealed_r;
	logic              verified_r;
	logic              wr_ok_r;
	logic              denied_r;
	logic              done_r;
	logic              seal_ok_r;
	logic              cksum_r;
	logic [EV_N-1:0]   irq_st_r;
	logic [EV_N-1:0]   irq_msk_r;
	logic              wait_r;

	// bus decode
	wire        req     = avs_read | avs_write;
	wire        acc     = req & ~wait_r;
	wire        acc_w   = acc & avs_write;
	wire        acc_r   = acc & avs_read;
	wire  [7:0] wbyte   = avs_writedata[7:0];
	wire        w_en    = acc_w & hit(avs_address, IDX_CMD_EN);
	wire        w_addr  = acc_w & hit(avs_address, IDX_ADDR);
	wire        w_data  = acc_w & hit(avs_address, IDX_DATA);
	wire        w_ctrl  = acc_w & hit(avs_address, IDX_CTRL);
	wire        w_use   = acc_w & hit(avs_address, IDX_USE);
	wire        w_msk   = acc_w & hit(avs_address, IDX_IRQ_MSK);
	wire        r_irq   = acc_r & hit(avs_address, IDX_IRQ_ST);

	// command acceptance
	wire        idle    = (state_r == ST_IDLE) && (ctrl_r == RST_BYTE);
	wire        enabled = cmd_en_r[CMD_EN_BIT];
	wire  [7:0] cmd_mask = (8'h01 << CTRL_WR) | (8'h01 << CTRL_RD)
		| (8'h01 << CTRL_SEAL);
	wire  [7:0] cmd_bits = wbyte & cmd_mask;
	wire        take_cmd = w_ctrl & enabled & idle & (cmd_bits != RST_BYTE);
	wire        refuse   = w_ctrl & wbyte[CTRL_WR] & ~(enabled & idle);

	// fuse store wiring
	wire  [7:0] st_rdata;
	wire        chk_run  = (state_r == ST_CHK);
	wire  [7:0] st_raddr = chk_run ? chk_cnt_r[7:0] : addr_r;
	wire        st_we    = (state_r == ST_WR_MERGE);
	wire  [7:0] st_wdata = st_rdata | data_r;
	wire        chk_last = chk_run && (chk_cnt_r == CHK_END);
	wire        chk_take = chk_run && (chk_cnt_r != 9'h000);

	// engine steps
	wire        go_wr    = (state_r == ST_IDLE) & ctrl_r[CTRL_WR];
	wire        go_rd    = (state_r == ST_IDLE) & ~ctrl_r[CTRL_WR]
		& ctrl_r[CTRL_RD];
	wire        go_seal  = (state_r == ST_IDLE) & ~ctrl_r[CTRL_WR]
		& ~ctrl_r[CTRL_RD] & ctrl_r[CTRL_SEAL];
	wire        wr_deny  = go_wr & sealed_r;
	wire        wr_fin   = (state_r == ST_WR_PROG) && (cnt_r == PROG_LAST);
	wire        rd_fin   = (state_r == ST_RD_TAKE);
	wire        op_fin   = wr_fin | wr_deny | rd_fin | go_seal;

	// interrupt events, set beats read clear
	wire [EV_N-1:0] ev = {chk_last, go_seal, rd_fin, wr_fin | wr_deny};
	// clear only what the read returned; an event on the capture edge stays
	wire [EV_N-1:0] irq_clr = r_irq ? avs_readdata[EV_N-1:0] : {EV_N{1'b0}};
	wire [EV_N-1:0] irq_st_nxt = (irq_st_r & ~irq_clr) | ev;

	// status words
	wire  [7:0] run_word = {5'h00, verified_r, sealed_r, used_r};
	wire  [7:0] res_word = {2'b00, cksum_r, seal_ok_r, done_r,
		idle & ~chk_run, denied_r, wr_ok_r};

	wire  [7:0] rd_mux =
		hit(avs_address, IDX_CMD_EN)  ? cmd_en_r :
		hit(avs_address, IDX_ADDR)    ? addr_r :
		hit(avs_address, IDX_DATA)    ? data_r :
		hit(avs_address, IDX_CTRL)    ? ctrl_r :
		hit(avs_address, IDX_RUN)     ? run_word :
		hit(avs_address, IDX_RES)     ? res_word :
		hit(avs_address, IDX_USE)     ? use_r :
		hit(avs_address, IDX_IRQ_ST)  ? {4'h0, irq_st_r} :
		hit(avs_address, IDX_IRQ_MSK) ? {4'h0, irq_msk_r} : RST_BYTE;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_CHK:      state_nxt = chk_last ? ST_IDLE : ST_CHK;
			ST_IDLE:
			begin
				if (go_wr & ~sealed_r)
					state_nxt = ST_WR_RD;
				else if (go_rd)
					state_nxt = ST_RD_WAIT;
			end
			ST_WR_RD:    state_nxt = ST_WR_MERGE;
			ST_WR_MERGE: state_nxt = ST_WR_PROG;
			ST_WR_PROG:  state_nxt = wr_fin ? ST_IDLE : ST_WR_PROG;
			ST_RD_WAIT:  state_nxt = ST_RD_TAKE;
			ST_RD_TAKE:  state_nxt = ST_IDLE;
			default:     state_nxt = ST_IDLE;
		endcase
	end

	fcae_store u_store (
		.clk   (clk),
		.we    (st_we),
		.waddr (addr_r),
		.wdata (st_wdata),
		.raddr (st_raddr),
		.rdata (st_rdata)
	);

	assign avs_waitrequest = wait_r;

	// one wait state per access so read data come from a register
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wait_r       <= 1'b1;
			avs_readdata <= RST_WORD;
		end
		else
		begin
			wait_r <= ~(req & wait_r);
			if (req & wait_r)
				avs_readdata <= {24'h000000, rd_mux};
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cmd_en_r  <= RST_BYTE;
			addr_r    <= RST_BYTE;
			use_r     <= RST_BYTE;
			irq_msk_r <= '0;
		end
		else
		begin
			if (w_en)
				cmd_en_r <= {7'h00, wbyte[CMD_EN_BIT]};
			if (w_addr)
				addr_r <= wbyte;
			if (w_use)
				use_r <= wbyte;
			if (w_msk)
				irq_msk_r <= wbyte[EV_N-1:0];
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			data_r <= RST_BYTE;
		else if (rd_fin)
			data_r <= st_rdata;
		else if (w_data)
			data_r <= wbyte;
	end

	// command bits, set by software, cleared by the engine on completion
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ctrl_r <= RST_BYTE;
		else if (take_cmd)
			ctrl_r <= cmd_bits;
		else if (wr_fin | wr_deny)
			ctrl_r[CTRL_WR] <= 1'b0;
		else if (rd_fin)
			ctrl_r[CTRL_RD] <= 1'b0;
		else if (go_seal)
			ctrl_r[CTRL_SEAL] <= 1'b0;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r <= ST_CHK;
			cnt_r   <= RST_BYTE;
			merge_r <= RST_BYTE;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r   <= (state_r == ST_WR_PROG) ? cnt_r + 8'h01 : RST_BYTE;
			if (st_we)
				merge_r <= st_wdata;
		end
	end

	// power-up walk of the whole store; the last location is the reference
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			chk_cnt_r  <= 9'h000;
			crc_r      <= CRC_INIT;
			verified_r <= 1'b0;
			cksum_r    <= 1'b0;
			used_r     <= 1'b0;
		end
		else
		begin
			if (chk_run)
				chk_cnt_r <= chk_cnt_r + 9'h001;
			if (chk_take & ~chk_last)
				crc_r <= crc8(crc_r, st_rdata);
			if (chk_last)
			begin
				verified_r <= 1'b1;
				cksum_r    <= (crc_r == st_rdata);
			end
			if ((chk_take & (st_rdata != RST_BYTE)) | st_we)
				used_r <= 1'b1;
		end
	end

	// results; sealing lives in a flop here, lost with power
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sealed_r  <= 1'b0;
			seal_ok_r <= 1'b0;
			wr_ok_r   <= 1'b0;
			denied_r  <= 1'b0;
			done_r    <= 1'b0;
		end
		else
		begin
			if (go_seal)
			begin
				sealed_r  <= 1'b1;
				seal_ok_r <= 1'b1;
			end
			if (take_cmd & cmd_bits[CTRL_WR])
				denied_r <= 1'b0;
			if (refuse | wr_deny)
				denied_r <= 1'b1;
			if (wr_deny)
				wr_ok_r <= 1'b0;
			else if (wr_fin)
				wr_ok_r <= (merge_r == data_r);
			if (take_cmd)
				done_r <= 1'b0;
			else if (op_fin)
				done_r <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			irq_st_r      <= '0;
			irq           <= 1'b0;
			cfg_use_store <= 1'b0;
		end
		else
		begin
			irq_st_r      <= irq_st_nxt;
			irq           <= |(irq_st_nxt & irq_msk_r);
			cfg_use_store <= (use_r != RST_BYTE);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_wr_start;
		$rose(ctrl_r[CTRL_WR]) && !sealed_r;
	endsequence

	sequence s_prog_hold;
		ctrl_r[CTRL_WR] [*8];
	endsequence

	chk_cmd_disabled: assert property (
		w_ctrl && !enabled |=> (ctrl_r & ~$past(ctrl_r)) == RST_BYTE)
		else $error("command taken while disabled");
	chk_addr_holder: assert property (
		w_addr |=> addr_r == $past(wbyte))
		else $error("address holder not loaded");
	chk_prog_time: assert property (
		s_wr_start |-> s_prog_hold ##16 !ctrl_r[CTRL_WR])
		else $error("programming bit timing wrong");
	chk_fetch_done: assert property (
		$rose(ctrl_r[CTRL_RD]) && !ctrl_r[CTRL_WR] |->
		##[2:4] !ctrl_r[CTRL_RD] && data_r == $past(st_rdata))
		else $error("fetch not completed");
	chk_seal_done: assert property (
		$rose(ctrl_r[CTRL_SEAL]) && ctrl_r[1:0] == 2'b00 |->
		##[1:2] !ctrl_r[CTRL_SEAL] && sealed_r && seal_ok_r)
		else $error("seal not completed");
	chk_seal_sticky: assert property (
		sealed_r |=> sealed_r)
		else $error("seal state dropped");
	chk_deny_sealed: assert property (
		$rose(ctrl_r[CTRL_WR]) && sealed_r |->
		##[1:2] denied_r && !ctrl_r[CTRL_WR] && !wr_ok_r)
		else $error("write to sealed space not refused");
	chk_check_once: assert property (
		$rose(verified_r) |-> $past(chk_last) && state_r == ST_IDLE)
		else $error("status check flag out of step");
	chk_use_select: assert property (
		##1 cfg_use_store == ($past(use_r) != RST_BYTE))
		else $error("use-store flag wrong");
	chk_ready_done: assert property (
		take_cmd |=> !res_word[RES_DONE] && !res_word[RES_RDY])
		else $error("ready or done not cleared on command");

endmodule

// ---- logic/fcae_pkg.sv ----
package fcae_pkg;

	// avalon byte address width; register index sits in bits 9:2
	localparam int          BUS_AW        = 10;
	localparam int          BUS_DW        = 32;

	// register indices, byte address is four times the index
	localparam logic [7:0]  IDX_CMD_EN    = 8'h51;
	localparam logic [7:0]  IDX_ADDR      = 8'h52;
	localparam logic [7:0]  IDX_DATA      = 8'h53;
	localparam logic [7:0]  IDX_CTRL      = 8'h54;
	localparam logic [7:0]  IDX_RUN       = 8'h56;
	localparam logic [7:0]  IDX_RES       = 8'h58;
	localparam logic [7:0]  IDX_USE       = 8'hDF;
	localparam logic [7:0]  IDX_IRQ_ST    = 8'h60;
	localparam logic [7:0]  IDX_IRQ_MSK   = 8'h61;

	// reset values
	localparam logic [7:0]  RST_BYTE      = 8'h00;
	localparam logic [31:0] RST_WORD      = 32'h0000_0000;

	// command enable and control fields
	localparam int          CMD_EN_BIT    = 0;
	localparam int          CTRL_WR       = 0;
	localparam int          CTRL_RD       = 1;
	localparam int          CTRL_SEAL     = 3;

	// run status fields
	localparam int          RUN_USED      = 0;
	localparam int          RUN_SEALED    = 1;
	localparam int          RUN_VERIFIED  = 2;

	// result status fields
	localparam int          RES_WR_OK     = 0;
	localparam int          RES_DENIED    = 1;
	localparam int          RES_RDY       = 2;
	localparam int          RES_DONE      = 3;
	localparam int          RES_SEAL_OK   = 4;
	localparam int          RES_CKSUM     = 5;

	// interrupt event bits
	localparam int          EV_WR         = 0;
	localparam int          EV_RD         = 1;
	localparam int          EV_SEAL       = 2;
	localparam int          EV_CHK        = 3;
	localparam int          EV_N          = 4;

	// programming time
	localparam int          CLK_PERIOD_NS = 50;
	localparam int          PROG_TIME_NS  = 1000;
	localparam int          PROG_CYCLES   =
		(PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0]  PROG_LAST     = 8'(PROG_CYCLES - 1);

	// checksum over locations 0..254, reference byte in the last one
	localparam logic [7:0]  CRC_POLY      = 8'h07;
	localparam logic [7:0]  CRC_INIT      = 8'h00;
	localparam logic [8:0]  CHK_END       = 9'h100;

	typedef enum logic [2:0] {
		ST_CHK,
		ST_IDLE,
		ST_WR_RD,
		ST_WR_MERGE,
		ST_WR_PROG,
		ST_RD_WAIT,
		ST_RD_TAKE
	} fcae_state_e;

endpackage

// ---- logic/fcae_store.sv ----
`timescale 1ns/1ps
module fcae_store
	import fcae_pkg::*;
(
	// clock
	input  wire logic       clk,
	// write port
	input  wire logic       we,
	input  wire logic [7:0] waddr,
	input  wire logic [7:0] wdata,
	// read port, data one cycle after address
	input  wire logic [7:0] raddr,
	output logic      [7:0] rdata
);

	logic [7:0] mem [0:255];

	// blank fuses read as zero
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = RST_BYTE;
	end

	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end

endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
	import fcae_pkg::*;
;
	typedef struct {
		logic [31:0] v;
		logic [31:0] m;
	} fcae_exp_s;

	localparam int          CYCLE_LIMIT = 20000;
	localparam logic [31:0] ALL         = 32'hFFFF_FFFF;

	// dut ports
	logic              clk;
	logic              rstn;
	logic [BUS_AW-1:0] avs_address;
	logic              avs_read;
	logic              avs_write;
	logic [BUS_DW-1:0] avs_writedata;
	logic [BUS_DW-1:0] avs_readdata;
	logic              avs_waitrequest;
	logic              irq;
	logic              cfg_use_store;
	// bench state
	fcae_exp_s         exp_q[$];
	int                n_mismatch;
	int                n_compared;
	int                n_cycle;
	logic [31:0]       rd_d;
	logic [7:0]        f_addr;
	logic [7:0]        f_data;
	logic [7:0]        use_v;

	fcae_engine u_dut (
		.clk             (clk),
		.rstn            (rstn),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.irq             (irq),
		.cfg_use_store   (cfg_use_store)
	);

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic note_bad(input logic [31:0] got, input logic [31:0] exp);
		n_mismatch++;
		$display("mismatch at %0t got %h expected %h", $time, got, exp);
	endtask

	// read data against the oldest note; a zero mask marks a poll
	task automatic cmp_read(input logic [31:0] got);
		fcae_exp_s e;
		if (exp_q.size() == 0)
		begin
			note_bad(got, 32'h0000_0000);
			return;
		end
		e = exp_q.pop_front();
		if (e.m != 32'h0000_0000)
		begin
			n_compared++;
			if ((got & e.m) !== (e.v & e.m))
				note_bad(got, e.v);
		end
	endtask

	task automatic cmp_level(input logic got, input logic exp);
		n_compared++;
		if (got !== exp)
			note_bad({31'h0, got}, {31'h0, exp});
	endtask

	// monitor: pre-edge values are what the master samples at this edge
	always @(posedge clk)
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
			cmp_read(avs_readdata);

	always @(posedge clk)
	begin
		n_cycle <= n_cycle + 1;
		if (n_cycle == CYCLE_LIMIT)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic bus_rd(input logic [7:0] idx, input logic [31:0] ev,
		input logic [31:0] em);
		exp_q.push_back('{ev, em});
		avs_address <= {idx, 2'b00};
		avs_read    <= 1'b1;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		rd_d = avs_readdata;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask

	task automatic bus_wr(input logic [7:0] idx, input logic [7:0] d);
		avs_address   <= {idx, 2'b00};
		avs_writedata <= {24'h00_0000, d};
		avs_write     <= 1'b1;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	// no result is trusted until the polled bit has reached the wanted value
	task automatic poll(input logic [7:0] idx, input int b, input logic v);
		do
			bus_rd(idx, 32'h0000_0000, 32'h0000_0000);
		while (rd_d[b] !== v);
	endtask

	// irq and use-select are registered, so give them two edges to land
	task automatic settle();
		repeat (2) @(posedge clk);
	endtask

	initial
	begin
		rstn          = 1'b0;
		avs_address   = '0;
		avs_read      = 1'b0;
		avs_write     = 1'b0;
		avs_writedata = '0;
		n_mismatch    = 0;
		n_compared    = 0;
		n_cycle       = 0;
		void'($urandom(32'haa34));
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		bus_rd(IDX_ADDR, 32'h0000_0000, ALL);
		bus_rd(IDX_DATA, 32'h0000_0000, ALL);
		bus_rd(IDX_CTRL, 32'h0000_0000, ALL);
		bus_rd(IDX_USE, 32'h0000_0000, ALL);
		cmp_level(cfg_use_store, 1'b0);
		poll(IDX_RES, RES_RDY, 1'b1);
		bus_rd(IDX_RUN, 32'h0000_0004, 32'h0000_00FF);
		bus_rd(IDX_RES, 32'h0000_0024, 32'h0000_00E4);
		$display("test reset_state done");
		f_addr = 8'($urandom_range(254, 0));
		f_data = 8'($urandom_range(255, 1));
		bus_wr(IDX_ADDR, f_addr);
		bus_wr(IDX_DATA, f_data);
		bus_rd(IDX_ADDR, {24'h00_0000, f_addr}, ALL);
		bus_rd(IDX_DATA, {24'h00_0000, f_data}, ALL);
		bus_wr(8'h57, 8'hFF);
		bus_rd(8'h57, 32'h0000_0000, ALL);
		$display("test holders done");
		bus_wr(IDX_CTRL, 8'h01);
		bus_rd(IDX_CTRL, 32'h0000_0000, 32'h0000_00FF);
		bus_rd(IDX_RES, 32'h0000_0002, 32'h0000_0002);
		cmp_level(irq, 1'b0);
		bus_rd(IDX_IRQ_ST, 32'h0000_0008, 32'h0000_0008);
		bus_rd(IDX_IRQ_ST, 32'h0000_0000, 32'h0000_000F);
		bus_wr(IDX_IRQ_MSK, 8'h0F);
		settle();
		cmp_level(irq, 1'b0);
		$display("test disabled done");
		bus_wr(IDX_CMD_EN, 8'h01);
		bus_wr(IDX_CTRL, 8'h01);
		bus_rd(IDX_CTRL, 32'h0000_0001, 32'h0000_0001);
		poll(IDX_CTRL, CTRL_WR, 1'b0);
		bus_rd(IDX_RES, 32'h0000_0009, 32'h0000_00CB);
		bus_rd(IDX_RUN, 32'h0000_0001, 32'h0000_0001);
		cmp_level(irq, 1'b1);
		bus_rd(IDX_IRQ_ST, 32'h0000_0001, 32'h0000_0001);
		settle();
		cmp_level(irq, 1'b0);
		$display("test program done");
		bus_wr(IDX_DATA, 8'h00);
		bus_wr(IDX_CTRL, 8'h02);
		poll(IDX_CTRL, CTRL_RD, 1'b0);
		bus_rd(IDX_DATA, {24'h00_0000, f_data}, ALL);
		cmp_level(irq, 1'b1);
		bus_rd(IDX_IRQ_ST, 32'h0000_0002, 32'h0000_0002);
		bus_wr(IDX_ADDR, f_addr + 8'h01);
		bus_wr(IDX_CTRL, 8'h02);
		poll(IDX_CTRL, CTRL_RD, 1'b0);
		bus_rd(IDX_DATA, 32'h0000_0000, ALL);
		$display("test fetch done");
		use_v = 8'($urandom_range(255, 1));
		bus_wr(IDX_USE, use_v);
		settle();
		cmp_level(cfg_use_store, 1'b1);
		bus_rd(IDX_USE, {24'h00_0000, use_v}, ALL);
		bus_wr(IDX_USE, 8'h00);
		settle();
		cmp_level(cfg_use_store, 1'b0);
		$display("test use_select done");
		bus_wr(IDX_IRQ_MSK, 8'h00);
		bus_wr(IDX_CTRL, 8'h08);
		poll(IDX_CTRL, CTRL_SEAL, 1'b0);
		bus_rd(IDX_RES, 32'h0000_0010, 32'h0000_0010);
		bus_rd(IDX_RUN, 32'h0000_0002, 32'h0000_0002);
		cmp_level(irq, 1'b0);
		bus_rd(IDX_IRQ_ST, 32'h0000_0004, 32'h0000_0004);
		bus_wr(IDX_CTRL, 8'h01);
		poll(IDX_CTRL, CTRL_WR, 1'b0);
		bus_rd(IDX_RES, 32'h0000_0002, 32'h0000_0003);
		$display("test seal done");
		bus_wr(IDX_CMD_EN, 8'h00);
		bus_wr(IDX_CTRL, 8'h02);
		bus_rd(IDX_CTRL, 32'h0000_0000, 32'h0000_00FF);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		bus_rd(IDX_ADDR, 32'h0000_0000, ALL);
		poll(IDX_RUN, RUN_VERIFIED, 1'b1);
		bus_rd(IDX_RUN, 32'h0000_0001, 32'h0000_0003);
		$display("test second_reset done");
		report_and_stop();
	end
endmodule
